// ==== core/pmtb_pkg.sv ====
package pmtb_pkg;

   // ****************************************************************
   // register word addresses
   // ****************************************************************
   localparam int PMTB_AW = 3;
   localparam logic [2:0] PMTB_A_PCTL = 3'h0;
   localparam logic [2:0] PMTB_A_PDIV = 3'h1;
   localparam logic [2:0] PMTB_A_PPER = 3'h2;
   localparam logic [2:0] PMTB_A_PCMP = 3'h3;
   localparam logic [2:0] PMTB_A_SCTL = 3'h4;
   localparam logic [2:0] PMTB_A_SPER = 3'h5;
   localparam logic [2:0] PMTB_A_SCMP = 3'h6;

   // ****************************************************************
   // field positions and reset values
   // ****************************************************************
   localparam int PMTB_B_MODULE_ON = 15;
   localparam int PMTB_B_HALT_IDLE = 13;
   localparam int PMTB_B_PENDING = 12;
   localparam int PMTB_CTL_W = 12;
   localparam int PMTB_DIV_W = 3;
   localparam logic [15:0] PMTB_PER_RST = 16'hFFF8;
   localparam logic [15:0] PMTB_CMP_RST = 16'h0000;
   localparam logic [2:0] PMTB_DIV_RST = 3'h0;
   localparam logic [2:0] PMTB_DIV_RSVD = 3'h7;
   localparam logic [2:0] PMTB_SRC_PIN = 3'h0;
   localparam logic [2:0] PMTB_SRC_TG16 = 3'h2;
   localparam logic [2:0] PMTB_SRC_TG17 = 3'h3;

   // control bits 11..0, shared layout of both time base controls
   typedef struct packed {
      logic event_irq_enable;
      logic immediate_period_load;
      logic sync_invert;
      logic sync_out_enable;
      logic ext_sync_enable;
      logic [2:0] sync_source_select;
      logic [3:0] event_postscale;
   } pmtb_ctl_t;

   localparam pmtb_ctl_t PMTB_CTL_RST = '0;

endpackage

// ==== core/pmtb_core.sv ====
// The implementer's own choices: the placing of the registers and the address-and-strobe port.
`timescale 1ns/100ps
module pmtb_core
   import pmtb_pkg::*;
#(
   parameter int DW = 16,
   parameter int PS_W = 4,
   parameter int PRE_W = 6
) (
   input wire logic clock,
   input wire logic rst,
   input wire logic [pmtb_pkg::PMTB_AW-1:0] reg_addr,
   input wire logic [DW-1:0] reg_wdata,
   input wire logic reg_wr,
   input wire logic reg_rd,
   output logic [DW-1:0] reg_rdata,
   input wire logic cpu_idle,
   input wire logic sync_in_a,
   input wire logic sync_in_b,
   input wire logic trig_gen_out_16,
   input wire logic trig_gen_out_17,
   output logic sync_out_a,
   output logic sync_out_a_oe,
   output logic sync_out_b,
   output logic sync_out_b_oe,
   output logic event_irq_a,
   output logic event_irq_b,
   output logic adc_event_trig
);
   import pmtb_pkg::*;

   // ****************************************************************
   // global control
   // ****************************************************************
   logic module_on_q;
   logic halt_in_idle_q;
   logic [PMTB_DIV_W-1:0] input_clock_divider_q;
   logic [PRE_W-1:0] pre_q;
   logic [PRE_W-1:0] pre_mask;
   logic run;
   logic tick;

   always_ff @(posedge clock or posedge rst) begin
      if (rst) begin
         module_on_q <= 1'b0;
         halt_in_idle_q <= 1'b0;
         input_clock_divider_q <= PMTB_DIV_RST;
      end else begin
         if (reg_wr && reg_addr == PMTB_A_PCTL) begin
            module_on_q <= reg_wdata[PMTB_B_MODULE_ON];
            halt_in_idle_q <= reg_wdata[PMTB_B_HALT_IDLE];
         end
         if (reg_wr && reg_addr == PMTB_A_PDIV) begin
            input_clock_divider_q <= reg_wdata[PMTB_DIV_W-1:0];
         end
      end
   end

   // reserved divider code falls back to divide-by-1
   always_comb begin
      if (input_clock_divider_q == PMTB_DIV_RSVD) begin
         pre_mask = '0;
      end else begin
         pre_mask = PRE_W'((1 << input_clock_divider_q) - 1);
      end
   end

   assign run = module_on_q && !(halt_in_idle_q && cpu_idle);
   assign tick = run && (pre_q == pre_mask);

   always_ff @(posedge clock or posedge rst) begin
      if (rst) begin
         pre_q <= '0;
      end else if (!run || tick) begin
         pre_q <= '0;
      end else begin
         pre_q <= pre_q + 1'b1;
      end
   end

   // ****************************************************************
   // sync input synchronisers
   // ****************************************************************
   logic [1:0] pin_s1_q;
   logic [1:0] pin_s2_q;
   logic [1:0] pin_s3_q;

   always_ff @(posedge clock or posedge rst) begin
      if (rst) begin
         pin_s1_q <= '0;
         pin_s2_q <= '0;
         pin_s3_q <= '0;
      end else begin
         pin_s1_q <= {sync_in_b, sync_in_a};
         pin_s2_q <= pin_s1_q;
         pin_s3_q <= pin_s2_q;
      end
   end

   // trigger generator outputs are on this clock: edge found directly
   logic tg16_q;
   logic tg17_q;

   always_ff @(posedge clock or posedge rst) begin
      if (rst) begin
         tg16_q <= 1'b0;
         tg17_q <= 1'b0;
      end else begin
         tg16_q <= trig_gen_out_16;
         tg17_q <= trig_gen_out_17;
      end
   end

   // ****************************************************************
   // two master time bases
   // ****************************************************************
   logic [1:0] trig_v;
   logic [1:0] so_v;
   logic [1:0] oe_v;
   logic [1:0] irq_v;
   pmtb_ctl_t ctl_v [2];
   logic [1:0] pend_v;
   logic [DW-1:0] per_v [2];
   logic [DW-1:0] cmp_v [2];

   for (genvar g = 0; g < 2; g++) begin : g_tb
      logic [2:0] a_ctl;
      logic [2:0] a_per;
      logic [2:0] a_cmp;
      pmtb_ctl_t ctl_q;
      logic pend_q;
      logic [DW-1:0] per_q;
      logic [DW-1:0] act_q;
      logic [DW-1:0] cmp_q;
      logic [DW-1:0] master_count_q;
      logic [PS_W-1:0] ps_q;
      logic trig_q;
      logic so_q;
      logic irq_q;
      logic pin_edge;
      logic tg_edge;
      logic sync_evt;
      logic boundary;
      logic match;
      logic trig_d;

      assign a_ctl = g ? PMTB_A_SCTL : PMTB_A_PCTL;
      assign a_per = g ? PMTB_A_SPER : PMTB_A_PPER;
      assign a_cmp = g ? PMTB_A_SCMP : PMTB_A_PCMP;

      always_ff @(posedge clock or posedge rst) begin
         if (rst) begin
            ctl_q <= PMTB_CTL_RST;
            per_q <= PMTB_PER_RST;
            cmp_q <= PMTB_CMP_RST;
         end else if (reg_wr) begin
            if (reg_addr == a_ctl) begin
               ctl_q <= pmtb_ctl_t'(reg_wdata[PMTB_CTL_W-1:0]);
            end
            if (reg_addr == a_per) begin
               per_q <= reg_wdata;
            end
            if (reg_addr == a_cmp) begin
               cmp_q <= reg_wdata;
            end
         end
      end

      // active-low pin sources are inverted before the edge detector; trigger generator edges are not
      assign pin_edge = (pin_s2_q[g] ^ ctl_q.sync_invert)
         && !(pin_s3_q[g] ^ ctl_q.sync_invert);
      assign tg_edge = (ctl_q.sync_source_select == PMTB_SRC_TG16) ? (trig_gen_out_16 && !tg16_q)
         : (ctl_q.sync_source_select == PMTB_SRC_TG17) ? (trig_gen_out_17 && !tg17_q)
         : 1'b0;
      assign sync_evt = run && ctl_q.ext_sync_enable
         && (((ctl_q.sync_source_select == PMTB_SRC_PIN) && pin_edge) || tg_edge);

      assign boundary = tick && (master_count_q >= act_q);
      assign match = tick && (master_count_q == cmp_q);
      assign trig_d = match && (ps_q == ctl_q.event_postscale);

      // buffered period reaches the counter at a boundary, on a sync event, while the module is off, or every cycle with immediate load
      always_ff @(posedge clock or posedge rst) begin
         if (rst) begin
            act_q <= PMTB_PER_RST;
         end else if (ctl_q.immediate_period_load || !module_on_q || boundary || sync_evt) begin
            act_q <= per_q;
         end
      end

      always_ff @(posedge clock or posedge rst) begin
         if (rst) begin
            master_count_q <= '0;
         end else if (!module_on_q || sync_evt || boundary) begin
            master_count_q <= '0;
         end else if (tick) begin
            master_count_q <= master_count_q + 1'b1;
         end
      end

      always_ff @(posedge clock or posedge rst) begin
         if (rst) begin
            ps_q <= '0;
         end else if (!module_on_q || trig_d) begin
            ps_q <= '0;
         end else if (match) begin
            ps_q <= ps_q + 1'b1;
         end
      end

      // set wins over the clear that comes from dropping the enable
      always_ff @(posedge clock or posedge rst) begin
         if (rst) begin
            pend_q <= 1'b0;
         end else if (trig_d) begin
            pend_q <= 1'b1;
         end else if (!ctl_q.event_irq_enable) begin
            pend_q <= 1'b0;
         end
      end

      always_ff @(posedge clock or posedge rst) begin
         if (rst) begin
            trig_q <= 1'b0;
            so_q <= 1'b0;
            irq_q <= 1'b0;
         end else begin
            trig_q <= trig_d;
            so_q <= boundary ^ ctl_q.sync_invert;
            irq_q <= (pend_q || trig_d) && ctl_q.event_irq_enable;
         end
      end

      assign trig_v[g] = trig_q;
      assign so_v[g] = so_q;
      assign irq_v[g] = irq_q;
      assign ctl_v[g] = ctl_q;
      assign pend_v[g] = pend_q;
      assign per_v[g] = per_q;
      assign cmp_v[g] = cmp_q;
   end

   // output enables follow the control bit, one cycle after the write
   logic [1:0] oe_q;
   logic adc_q;

   always_ff @(posedge clock or posedge rst) begin
      if (rst) begin
         oe_q <= '0;
         adc_q <= 1'b0;
      end else begin
         oe_q <= {ctl_v[1].sync_out_enable, ctl_v[0].sync_out_enable};
         adc_q <= |trig_v;
      end
   end

   assign oe_v = oe_q;
   assign sync_out_a = so_v[0];
   assign sync_out_b = so_v[1];
   assign sync_out_a_oe = oe_v[0];
   assign sync_out_b_oe = oe_v[1];
   assign event_irq_a = irq_v[0];
   assign event_irq_b = irq_v[1];
   assign adc_event_trig = adc_q;

   // ****************************************************************
   // register read
   // ****************************************************************
   logic [DW-1:0] rd_d;
   logic [DW-1:0] rdata_q;

   always_comb begin
      rd_d = '0;
      case (reg_addr)
         PMTB_A_PCTL: begin
            rd_d[PMTB_CTL_W-1:0] = ctl_v[0];
            rd_d[PMTB_B_PENDING] = pend_v[0];
            rd_d[PMTB_B_HALT_IDLE] = halt_in_idle_q;
            rd_d[PMTB_B_MODULE_ON] = module_on_q;
         end
         PMTB_A_PDIV: rd_d[PMTB_DIV_W-1:0] = input_clock_divider_q;
         PMTB_A_PPER: rd_d = per_v[0];
         PMTB_A_PCMP: rd_d = cmp_v[0];
         PMTB_A_SCTL: begin
            rd_d[PMTB_CTL_W-1:0] = ctl_v[1];
            rd_d[PMTB_B_PENDING] = pend_v[1];
         end
         PMTB_A_SPER: rd_d = per_v[1];
         PMTB_A_SCMP: rd_d = cmp_v[1];
         default: rd_d = '0;
      endcase
   end

   always_ff @(posedge clock or posedge rst) begin
      if (rst) begin
         rdata_q <= '0;
      end else if (reg_rd) begin
         rdata_q <= rd_d;
      end else begin
         rdata_q <= '0;
      end
   end

   assign reg_rdata = rdata_q;

endmodule

// ==== testbench/pmtb_props.sv ====
`timescale 1ns/100ps
module pmtb_props (
   input wire logic clock,
   input wire logic rst,
   input wire logic [pmtb_pkg::PMTB_AW-1:0] reg_addr,
   input wire logic [15:0] reg_wdata,
   input wire logic reg_wr,
   input wire logic reg_rd,
   input wire logic [15:0] reg_rdata,
   input wire logic sync_out_a,
   input wire logic sync_out_a_oe,
   input wire logic sync_out_b,
   input wire logic sync_out_b_oe,
   input wire logic event_irq_a,
   input wire logic event_irq_b,
   input wire logic adc_event_trig
);
   import pmtb_pkg::*;
   // ****************
   // control shadows; age_q masks the cycles a control write takes to settle
   // ****************
   logic [15:0] ctl_a_q;
   logic [15:0] ctl_b_q;
   logic [2:0] age_q;
   always_ff @(posedge clock or posedge rst) begin
      if (rst) begin
         ctl_a_q <= '0;
         ctl_b_q <= '0;
      end else if (reg_wr && reg_addr == PMTB_A_PCTL) begin
         ctl_a_q <= reg_wdata;
      end else if (reg_wr && reg_addr == PMTB_A_SCTL) begin
         ctl_b_q <= reg_wdata;
      end
   end
   always_ff @(posedge clock or posedge rst) begin
      if (rst) begin
         age_q <= '0;
      end else if (reg_wr) begin
         age_q <= '0;
      end else if (age_q != 3'h7) begin
         age_q <= age_q + 3'h1;
      end
   end
   default clocking dc @(posedge clock);
   endclocking
   default disable iff (rst);
   property p_rd_idle;
      !$past(reg_rd) |-> reg_rdata == 16'h0000;
   endproperty
   a_rd_idle: assert property (p_rd_idle) else $error("rd idle");
   property p_rd_div;
      $past(reg_rd) && $past(reg_addr) == PMTB_A_PDIV |-> reg_rdata[15:3] == 13'h0000;
   endproperty
   a_rd_div: assert property (p_rd_div) else $error("rd div");
   property p_rd_sctl;
      $past(reg_rd) && $past(reg_addr) == PMTB_A_SCTL |-> reg_rdata[15:13] == 3'h0;
   endproperty
   a_rd_sctl: assert property (p_rd_sctl) else $error("rd sctl");
   property p_oe_a;
      age_q > 3'h3 |-> sync_out_a_oe == ctl_a_q[8];
   endproperty
   a_oe_a: assert property (p_oe_a) else $error("oe a");
   property p_oe_b;
      age_q > 3'h3 |-> sync_out_b_oe == ctl_b_q[8];
   endproperty
   a_oe_b: assert property (p_oe_b) else $error("oe b");
   property p_irq_a;
      event_irq_a && age_q != 3'h0 |-> ctl_a_q[11];
   endproperty
   a_irq_a: assert property (p_irq_a) else $error("irq a");
   property p_irq_b;
      event_irq_b && age_q != 3'h0 |-> ctl_b_q[11];
   endproperty
   a_irq_b: assert property (p_irq_b) else $error("irq b");
   property p_off;
      !ctl_a_q[15] && age_q > 3'h3 |->
         sync_out_a == ctl_a_q[9] && sync_out_b == ctl_b_q[9] && !adc_event_trig;
   endproperty
   a_off: assert property (p_off) else $error("off");
   property p_pulse_a;
      ctl_a_q[15] && age_q > 3'h3 && sync_out_a != ctl_a_q[9] |=> sync_out_a == ctl_a_q[9];
   endproperty
   a_pulse_a: assert property (p_pulse_a) else $error("pulse a");
endmodule
bind pmtb_core pmtb_props i_props (.clock(clock), .rst(rst), .reg_addr(reg_addr),
   .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
   .sync_out_a(sync_out_a), .sync_out_a_oe(sync_out_a_oe), .sync_out_b(sync_out_b),
   .sync_out_b_oe(sync_out_b_oe), .event_irq_a(event_irq_a), .event_irq_b(event_irq_b),
   .adc_event_trig(adc_event_trig));

// ==== testbench/pmtb_partner.sv ====
`timescale 1ns/100ps
module pmtb_partner (
   input wire logic clock,
   input wire logic [3:0] fire,
   input wire logic [1:0] inv,
   input wire logic adc_event_trig,
   output logic sync_in_a,
   output logic sync_in_b,
   output logic trig_gen_out_16,
   output logic trig_gen_out_17,
   output int adc_seen
);
   // ****************
   // sync sources and the converter that counts triggers
   // ****************
   // one process drives every output; adc_seen is two-state and starts at zero
   always @(posedge clock) begin
      sync_in_a <= fire[0] ^ inv[0];
      sync_in_b <= fire[1] ^ inv[1];
      trig_gen_out_16 <= fire[2];
      trig_gen_out_17 <= fire[3];
      if (adc_event_trig) begin
         adc_seen <= adc_seen + 1;
      end
   end
endmodule

// ==== testbench/pwm_master_time_base_control_bench.sv ====
`timescale 1ns/100ps
`define CHK(g, e) begin compares++; if ((g) !== (e)) begin error_cnt++; $display("MISMATCH t=%0t got=%h exp=%h", $time, g, e); end end
module pwm_master_time_base_control_bench;
   import pmtb_pkg::*;
   logic clock, rst, reg_wr, reg_rd, cpu_idle, rd_seen, s_a, s_b, t16, t17;
   logic so_a, so_a_oe, so_b, so_b_oe, irq_a, irq_b, adc;
   logic [2:0] reg_addr;
   logic [15:0] reg_wdata, reg_rdata, r, e;
   logic [15:0] exp_q[$];
   logic [3:0] fire, tick_q;
   logic [1:0] inv;
   int error_cnt, compares, adc_seen, n, m;
   logic [15:0] rst_v [8] = '{16'h0, 16'h0, 16'hFFF8, 16'h0, 16'h0, 16'hFFF8, 16'h0, 16'h0};
   int cfg [8][4] = '{'{0, 0, 3, 4}, '{0, 1, 3, 8}, '{0, 15, 3, 64}, '{1, 0, 3, 8},
      '{2, 0, 3, 16}, '{6, 0, 3, 256}, '{7, 0, 3, 4}, '{0, 0, 7, 8}};
   int src [4][2] = '{'{0, 10}, '{2, 10}, '{3, 10}, '{1, 16}};
   pmtb_core i_dut (.clock(clock), .rst(rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
      .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .cpu_idle(cpu_idle),
      .sync_in_a(s_a), .sync_in_b(s_b), .trig_gen_out_16(t16), .trig_gen_out_17(t17),
      .sync_out_a(so_a), .sync_out_a_oe(so_a_oe), .sync_out_b(so_b), .sync_out_b_oe(so_b_oe),
      .event_irq_a(irq_a), .event_irq_b(irq_b), .adc_event_trig(adc));
   pmtb_partner i_far (.clock(clock), .fire(fire), .inv(inv), .adc_event_trig(adc),
      .sync_in_a(s_a), .sync_in_b(s_b), .trig_gen_out_16(t16), .trig_gen_out_17(t17),
      .adc_seen(adc_seen));
   initial begin
      clock = 1'b0;
      forever #2 clock = ~clock;
   end
   function automatic logic [15:0] lfsr(input logic [15:0] s);
      return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
   endfunction
   task automatic stop_test();
      $display("errors %0d compares %0d", error_cnt, compares);
      if (error_cnt == 0 && compares > 0) begin
         $display("== PASSED ==");
      end else begin
         $display("== FAILED ==");
      end
      $finish;
   endtask
   task automatic wr(input logic [2:0] a, input logic [15:0] d);
      reg_addr <= a;
      reg_wdata <= d;
      reg_wr <= 1'b1;
      @(posedge clock);
      reg_wr <= 1'b0;
      @(posedge clock);
   endtask
   task automatic rd(input logic [2:0] a, input logic [15:0] d);
      exp_q.push_back(d);
      reg_addr <= a;
      reg_rd <= 1'b1;
      @(posedge clock);
      reg_rd <= 1'b0;
      @(posedge clock);
   endtask
   // the first gaps after a restart are irregular, so only the third is judged
   task automatic gap(input int x);
      repeat (3) begin
         n = 0;
         do begin
            @(posedge clock);
            n++;
         end while (adc !== 1'b1 && n < 3000);
         if (n >= 3000) begin
            error_cnt++;
            stop_test();
         end
      end
      `CHK(n, x)
   endtask
   // sync sources fire every ten cycles on both pins and both trigger outputs
   always @(posedge clock) begin
      if (rst) begin
         rd_seen <= 1'b0;
         tick_q <= 4'h0;
         fire <= 4'h0;
      end else begin
         if (rd_seen) begin
            e = exp_q.pop_front();
            `CHK(reg_rdata, e)
         end
         rd_seen <= reg_rd;
         tick_q <= (tick_q == 4'h9) ? 4'h0 : tick_q + 4'h1;
         fire <= (tick_q == 4'h0) ? 4'hF : 4'h0;
      end
   end
   initial begin
      {rst, reg_wr, reg_rd, cpu_idle} = 4'h8;
      {reg_addr, reg_wdata, inv} = '0;
      r = lfsr(16'hE3E8);
      repeat (8) @(posedge clock);
      rst <= 1'b0;
      @(posedge clock);
      foreach (rst_v[i])
         rd(3'(i), rst_v[i]);
      wr(PMTB_A_PCMP, r);
      rd(PMTB_A_PCMP, r);
      wr(PMTB_A_PDIV, 16'hFFFF);
      rd(PMTB_A_PDIV, 16'h0007);
      wr(PMTB_A_SCTL, 16'hFFFF);
      rd(PMTB_A_SCTL, 16'h0FFF);
      wr(3'h7, r);
      rd(3'h7, 16'h0000);
      wr(PMTB_A_PCTL, 16'h5000);
      rd(PMTB_A_PCTL, 16'h0000);
      wr(PMTB_A_SCTL, 16'h0B00);
      wr(PMTB_A_SCMP, 16'hFFFF);
      wr(PMTB_A_PCMP, 16'h0001);
      foreach (cfg[i]) begin
         wr(PMTB_A_PCTL, 16'h0000);
         wr(PMTB_A_PDIV, 16'(cfg[i][0]));
         wr(PMTB_A_PPER, 16'(cfg[i][2]));
         wr(PMTB_A_PCTL, 16'h8000 | 16'(cfg[i][1]));
         gap(cfg[i][3]);
      end
      wr(PMTB_A_PPER, 16'h0003);
      gap(4);
      wr(PMTB_A_PCTL, 16'h0000);
      wr(PMTB_A_PCTL, 16'hA400);
      wr(PMTB_A_PPER, 16'h0007);
      gap(8);
      cpu_idle <= 1'b1;
      repeat (20) @(posedge clock);
      m = adc_seen;
      repeat (50) @(posedge clock);
      `CHK(adc_seen, m)
      cpu_idle <= 1'b0;
      gap(8);
      wr(PMTB_A_PCTL, 16'h0000);
      wr(PMTB_A_PCTL, 16'h8800);
      n = 0;
      while (irq_a !== 1'b1 && n < 100) begin
         @(posedge clock);
         n++;
      end
      `CHK(irq_a, 1'b1)
      if (n >= 100) stop_test();
      rd(PMTB_A_PCTL, 16'h9800);
      wr(PMTB_A_PCTL, 16'h0000);
      rd(PMTB_A_PCTL, 16'h0000);
      `CHK(irq_a, 1'b0)
      inv <= 2'b01;
      wr(PMTB_A_PPER, 16'h000F);
      foreach (src[i]) begin
         wr(PMTB_A_PCTL, 16'h0000);
         wr(PMTB_A_PCTL, 16'h8180 | (16'(src[i][0] == 0) << 9) | (16'(src[i][0]) << 4));
         gap(src[i][1]);
      end
      `CHK(so_a_oe, 1'b1)
      wr(PMTB_A_PCTL, 16'h0000);
      @(posedge clock);
      `CHK(so_a_oe, 1'b0)
      // secondary base alone feeds the converter: primary compare is out of reach
      inv <= 2'b11;
      wr(PMTB_A_PCMP, 16'hFFFF);
      wr(PMTB_A_SPER, 16'h000F);
      wr(PMTB_A_SCMP, 16'h0002);
      wr(PMTB_A_SCTL, 16'h0B80);
      wr(PMTB_A_PCTL, 16'h8000);
      gap(10);
      `CHK(irq_b, 1'b1)
      `CHK(so_b_oe, 1'b1)
      rd(PMTB_A_SCTL, 16'h1B80);
      n = 0;
      while (so_a !== 1'b1 && n < 40) begin
         @(posedge clock);
         n++;
      end
      `CHK(so_a, 1'b1)
      `CHK(adc_seen != 0, 1'b1)
      stop_test();
   end
endmodule
